// ### rtl/cmcs_regs.vh
// register offsets, field positions, reset values and timing counts for the channel config block
`ifndef CMCS_REGS_VH
`define CMCS_REGS_VH
`define CMCS_OFF_CMD 12'h000
`define CMCS_OFF_CFG 12'h004
`define CMCS_OFF_GAIN 12'h008
`define CMCS_OFF_OFST 12'h00C
`define CMCS_OFF_LABEL 12'h010
`define CMCS_OFF_FREQ 12'h014
`define CMCS_OFF_RAW 12'h018
`define CMCS_OFF_RESULT 12'h01C
`define CMCS_OFF_STATUS 12'h020
`define CMCS_OFF_DELAY 12'h024
`define CMCS_OFF_TMO 12'h028
`define CMCS_OFF_ALARM 12'h02C
`define CMCS_OFF_DLYSET 12'h030
// command codes written to the command register bits [3:0]
`define CMCS_CMD_SELECT 4'h1
`define CMCS_CMD_FUNC 4'h2
`define CMCS_CMD_CONF 4'h3
`define CMCS_CMD_FRESET 4'h4
`define CMCS_CMD_PRESET 4'h5
`define CMCS_CMD_CRESET 4'h6
`define CMCS_CMD_SCANOFF 4'h7
`define CMCS_CMD_SCANON 4'h8
`define CMCS_CMD_NULL 4'h9
`define CMCS_CMD_CFGCHG 4'hA
`define CMCS_CMD_DMMOFF 4'hB
`define CMCS_CMD_SCALEON 4'hC
`define CMCS_CMD_SCALEOFF 4'hD
`define CMCS_CMD_OCOMP 4'hE
// function codes
`define CMCS_FN_DCV 3'h0
`define CMCS_FN_ACV 3'h1
`define CMCS_FN_OHM2 3'h2
`define CMCS_FN_OHM4 3'h3
`define CMCS_FN_DCI 3'h4
`define CMCS_FN_ACI 3'h5
`define CMCS_FN_FREQ 3'h6
`define CMCS_FN_TEMP 3'h7
// filter / timeout speed codes
`define CMCS_SPD_SLOW 2'h0
`define CMCS_SPD_MED 2'h1
`define CMCS_SPD_FAST 2'h2
`define CMCS_THR_MED_HZ 20
`define CMCS_THR_FAST_HZ 200
`define CMCS_THR_SLOW_HZ 3
// settling delays and timeouts in milliseconds
`define CMCS_DLY_SLOW_MS 7000
`define CMCS_DLY_MED_MS 1000
`define CMCS_DLY_FAST_MS 120
`define CMCS_MIN_SLOW_MS 1500
`define CMCS_MIN_MED_MS 200
`define CMCS_MIN_FAST_MS 20
`define CMCS_TMO_SLOW_MS 1000
`define CMCS_TMO_MED_MS 100
`define CMCS_TMO_FAST_MS 10
`define CMCS_CLK_MHZ 100
`define CMCS_GAIN_ONE 32'h00010000
`define CMCS_LIMIT 32'h7FFF0000
`define CMCS_LBL_DEFAULT 24'h000000
`define CMCS_CH_CUR_A 7'd21
`define CMCS_CH_CUR_B 7'd22
`define CMCS_ST_BUSY 0
`define CMCS_ST_ERR 1
`endif

// ### rtl/cmcs_mem.v
// per-channel configuration word store with registered read data
`timescale 1ns/1ps
module cmcs_mem #(
  parameter AW = 7,
  parameter DW = 128
) (
  input wire clock,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  always @(posedge clock)
  begin
    if (we)
      mem[waddr] <= wdata;
    rdata <= mem[raddr];
  end
endmodule

// ### rtl/cmcs_scale.v
// registered gain times raw minus offset, fixed point 16.16 gain
`timescale 1ns/1ps
module cmcs_scale (
  input wire clock,
  input wire rst_n,
  input wire start,
  input wire [31:0] gain,
  input wire [31:0] raw,
  input wire [31:0] offset,
  output reg [31:0] result,
  output reg done
);
  wire signed [63:0] prod;
  assign prod = $signed(gain) * $signed(raw);
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      result <= 32'h00000000;
      done <= 1'b0;
    end
    else
    begin
      done <= start;
      if (start)
        result <= prod[47:16] - offset; // [RL12]
    end
  end
endmodule

// ### rtl/cmcs_top.v
// channel measurement configuration store and reading scaler, APB slave
// Operation
// [RL1] offset-comp result is source-on minus source-off
// [RL2] offset comp only ohms, three lowest ranges
// [RL3] function change, factory reset clear offset comp
// [RL4] host addresses 4-wire comp to source channel
// [RL5] current functions only on channels 21, 22
// [RL6] ac filter chosen by 3/20/200 Hz thresholds
// [RL7] settling delay defaults and minimums per filter
// [RL8] filter to medium on function change, reset
// [RL9] configure command sets filter medium
// [RL10] frequency timeout 1 s, 100 ms, 10 ms
// [RL11] timeout medium on change, reset, configure
// [RL12] scaled reading is gain times raw minus offset
// [RL13] no scaling on digital channels
// [RL14] config change disables scaling, gain 1 offset 0
// [RL15] scaling enable clears and disables alarms
// [RL16] scan removal keeps values, re-add restores
// [RL17] null stores one measurement as offset
// [RL18] monitor readings get gain and offset
// [RL19] label three chars, letter or hash first
// [RL20] reject gain or offset beyond limit
// [RL21] configure command sets gain 1 offset 0
// [RL22] factory reset clears scaling on all channels
// [RL23] bad label rejected, old label kept
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "cmcs_regs.vh"
module cmcs_top #(
  parameter CHW = 7
) (
  input wire clock,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output reg meas_req,
  output reg meas_src_on,
  input wire meas_valid,
  input wire [31:0] meas_data,
  input wire monitor_active
);
  // record: [0]scale_en [1]scale_saved [2]ocomp [4:3]filt [6:5]tmo [9:7]fn [10]alarm_en
  // [42:11]gain [74:43]offset [98:75]label [99]digital
  localparam S_IDLE = 3'd0;
  localparam S_RD = 3'd1;
  localparam S_EXEC = 3'd2;
  localparam S_MEAS = 3'd3;
  localparam S_MEAS2 = 3'd4;
  localparam S_SCALE = 3'd5;
  localparam S_WB = 3'd6;
  localparam S_WIPE = 3'd7;

  reg [2:0] state_r;
  reg [CHW-1:0] chan_r;
  reg [CHW-1:0] wipe_r;
  reg [3:0] cmd_r;
  reg [31:0] arg_r;
  reg [127:0] rec_r;
  reg [31:0] raw_r;
  reg [31:0] first_r;
  reg [31:0] result_r;
  reg [31:0] freq_r;
  reg [2:0] range_r;
  reg err_r;
  reg null_r;
  reg mem_we_r;
  reg [CHW-1:0] mem_wa_r;
  reg scale_go_r;
  wire [127:0] mem_rd;
  wire [31:0] scaled;
  wire scale_done;

  cmcs_mem #(.AW(CHW), .DW(128)) u_mem (
    .clock(clock),
    .we(mem_we_r),
    .waddr(mem_wa_r),
    .wdata(rec_r),
    .raddr(chan_r),
    .rdata(mem_rd)
  );

  cmcs_scale u_scale (
    .clock(clock),
    .rst_n(rst_n),
    .start(scale_go_r),
    .gain(rec_r[42:11]),
    .raw(raw_r),
    .offset(rec_r[74:43]),
    .result(scaled),
    .done(scale_done)
  );

  function [1:0] speed_of;
    input [31:0] hz;
    begin
      if (hz >= `CMCS_THR_FAST_HZ)
        speed_of = `CMCS_SPD_FAST;
      else if (hz >= `CMCS_THR_MED_HZ)
        speed_of = `CMCS_SPD_MED;
      else
        speed_of = `CMCS_SPD_SLOW;
    end
  endfunction

  function over_limit;
    input [31:0] v;
    begin
      over_limit = v[31] ? ((~v + 32'h00000001) > `CMCS_LIMIT) : (v > `CMCS_LIMIT);
    end
  endfunction

  function label_ok;
    input [23:0] l;
    reg [7:0] c;
    integer i;
    begin
      label_ok = (l[23:16] == 8'h23) || (l[23:16] >= 8'h41 && l[23:16] <= 8'h5A);
      for (i = 0; i < 2; i = i + 1)
      begin
        c = l[8*i +: 8];
        if (!(c == 8'h00 || c == 8'h5F || (c >= 8'h30 && c <= 8'h39) ||
              (c >= 8'h41 && c <= 8'h5A)))
          label_ok = 1'b0;
      end
      if (l[15:8] == 8'h00 && l[7:0] != 8'h00)
        label_ok = 1'b0;
    end
  endfunction

  // defaults after configure: gain one, offset zero, medium filter and timeout
  function [127:0] conf_default;
    input [127:0] r;
    begin
      conf_default = r;
      conf_default[0] = 1'b0;
      conf_default[1] = 1'b0;
      conf_default[4:3] = `CMCS_SPD_MED;
      conf_default[6:5] = `CMCS_SPD_MED;
      conf_default[42:11] = `CMCS_GAIN_ONE;
      conf_default[74:43] = 32'h00000000;
    end
  endfunction

  wire busy = (state_r != S_IDLE);
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  wire [1:0] filt = rec_r[4:3];
  wire [1:0] tmo = rec_r[6:5];
  wire ocomp_active = rec_r[2] && (rec_r[9:7] == `CMCS_FN_OHM2 || rec_r[9:7] == `CMCS_FN_OHM4)
    && (range_r <= 3'd2); // [RL2]
  reg [31:0] dly_ms;
  reg [31:0] min_ms;
  reg [31:0] tmo_ms;
  always @*
  begin
    case (filt)
      `CMCS_SPD_SLOW:
      begin
        dly_ms = `CMCS_DLY_SLOW_MS; // [RL7]
        min_ms = `CMCS_MIN_SLOW_MS;
      end
      `CMCS_SPD_FAST:
      begin
        dly_ms = `CMCS_DLY_FAST_MS;
        min_ms = `CMCS_MIN_FAST_MS;
      end
      default:
      begin
        dly_ms = `CMCS_DLY_MED_MS;
        min_ms = `CMCS_MIN_MED_MS;
      end
    endcase
    case (tmo)
      `CMCS_SPD_SLOW: tmo_ms = `CMCS_TMO_SLOW_MS; // [RL10]
      `CMCS_SPD_FAST: tmo_ms = `CMCS_TMO_FAST_MS;
      default: tmo_ms = `CMCS_TMO_MED_MS;
    endcase
  end

  always @*
  begin
    case (paddr)
      `CMCS_OFF_CFG: prdata = {16'h0000, range_r, 1'b0, rec_r[99], rec_r[10], rec_r[9:7],
        rec_r[6:3], rec_r[2:0]};
      `CMCS_OFF_GAIN: prdata = rec_r[42:11];
      `CMCS_OFF_OFST: prdata = rec_r[74:43];
      `CMCS_OFF_LABEL: prdata = {8'h00, rec_r[98:75]};
      `CMCS_OFF_FREQ: prdata = freq_r;
      `CMCS_OFF_RAW: prdata = raw_r;
      `CMCS_OFF_RESULT: prdata = result_r;
      `CMCS_OFF_STATUS: prdata = {30'h00000000, err_r, busy};
      `CMCS_OFF_DELAY: prdata = dly_ms;
      `CMCS_OFF_TMO: prdata = tmo_ms;
      `CMCS_OFF_DLYSET: prdata = min_ms;
      default: prdata = 32'h00000000;
    endcase
  end

  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_r <= S_IDLE;
      chan_r <= {CHW{1'b0}};
      wipe_r <= {CHW{1'b0}};
      cmd_r <= 4'h0;
      arg_r <= 32'h00000000;
      rec_r <= 128'h0;
      raw_r <= 32'h00000000;
      first_r <= 32'h00000000;
      result_r <= 32'h00000000;
      freq_r <= 32'h00000000;
      range_r <= 3'd0;
      err_r <= 1'b0;
      null_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_wa_r <= {CHW{1'b0}};
      scale_go_r <= 1'b0;
      meas_req <= 1'b0;
      meas_src_on <= 1'b0;
    end
    else
    begin
      mem_we_r <= 1'b0;
      scale_go_r <= 1'b0;
      meas_req <= 1'b0;
      case (state_r)
        S_IDLE:
        begin
          if (wr && paddr == `CMCS_OFF_CMD)
          begin
            cmd_r <= pwdata[3:0];
            arg_r <= {16'h0000, pwdata[31:16]};
            err_r <= 1'b0;
            if (pwdata[3:0] == `CMCS_CMD_SELECT)
            begin
              chan_r <= pwdata[8+CHW-1:8];
              state_r <= S_RD;
            end
            else if (pwdata[3:0] == `CMCS_CMD_FRESET)
            begin
              wipe_r <= {CHW{1'b0}};
              rec_r <= conf_default(128'h0); // [RL22]
              state_r <= S_WIPE;
            end
            else
              state_r <= S_EXEC;
          end
          else if (wr && paddr == `CMCS_OFF_GAIN)
          begin
            if (over_limit(pwdata))
              err_r <= 1'b1; // [RL20]
            else
            begin
              rec_r[42:11] <= pwdata;
              mem_we_r <= 1'b1;
              mem_wa_r <= chan_r;
            end
          end
          else if (wr && paddr == `CMCS_OFF_OFST)
          begin
            if (over_limit(pwdata))
              err_r <= 1'b1; // [RL20]
            else
            begin
              rec_r[74:43] <= pwdata;
              mem_we_r <= 1'b1;
              mem_wa_r <= chan_r;
            end
          end
          else if (wr && paddr == `CMCS_OFF_LABEL)
          begin
            if (label_ok(pwdata[23:0])) // [RL19]
            begin
              rec_r[98:75] <= pwdata[23:0];
              mem_we_r <= 1'b1;
              mem_wa_r <= chan_r;
            end
            else
              err_r <= 1'b1; // [RL23]
          end
          else if (wr && paddr == `CMCS_OFF_FREQ)
          begin
            freq_r <= pwdata;
            if (rec_r[9:7] == `CMCS_FN_FREQ)
              rec_r[6:5] <= speed_of(pwdata); // [RL10]
            else if (rec_r[9:7] == `CMCS_FN_ACV || rec_r[9:7] == `CMCS_FN_ACI)
              rec_r[4:3] <= speed_of(pwdata); // [RL6]
            mem_we_r <= 1'b1;
            mem_wa_r <= chan_r;
          end
          else if (wr && paddr == `CMCS_OFF_CFG)
          begin
            range_r <= pwdata[18:16];
            rec_r[99] <= pwdata[11];
            // alarm enable stands in for the alarm block's limit state
            rec_r[10] <= pwdata[10];
            mem_we_r <= 1'b1;
            mem_wa_r <= chan_r;
          end
          else if (meas_valid && monitor_active)
          begin
            raw_r <= meas_data;
            scale_go_r <= 1'b1; // [RL18]
            state_r <= S_SCALE;
          end
        end
        S_RD:
          state_r <= S_WB;
        S_WB:
        begin
          rec_r <= mem_rd;
          state_r <= S_IDLE;
        end
        S_EXEC:
        begin
          state_r <= S_IDLE;
          mem_we_r <= 1'b1;
          mem_wa_r <= chan_r;
          case (cmd_r)
            `CMCS_CMD_FUNC, `CMCS_CMD_CONF:
            begin
              if ((arg_r[2:0] == `CMCS_FN_DCI || arg_r[2:0] == `CMCS_FN_ACI) &&
                  chan_r != `CMCS_CH_CUR_A && chan_r != `CMCS_CH_CUR_B)
              begin
                err_r <= 1'b1; // [RL5]
                mem_we_r <= 1'b0;
              end
              else
              begin
                rec_r <= conf_default(rec_r); // [RL9] [RL11] [RL21] [RL14]
                rec_r[9:7] <= arg_r[2:0];
                if (arg_r[2:0] != rec_r[9:7] || cmd_r == `CMCS_CMD_FUNC)
                  rec_r[2] <= 1'b0; // [RL3] [RL8]
              end
            end
            `CMCS_CMD_CFGCHG, `CMCS_CMD_DMMOFF:
            begin
              rec_r[0] <= 1'b0; // [RL14]
              rec_r[1] <= 1'b0;
              rec_r[42:11] <= `CMCS_GAIN_ONE;
              rec_r[74:43] <= 32'h00000000;
            end
            `CMCS_CMD_SCALEON:
            begin
              if (rec_r[99])
              begin
                err_r <= 1'b1; // [RL13]
                mem_we_r <= 1'b0;
              end
              else
              begin
                rec_r[0] <= 1'b1;
                rec_r[10] <= 1'b0; // [RL15]
              end
            end
            `CMCS_CMD_SCALEOFF:
              rec_r[0] <= 1'b0;
            `CMCS_CMD_SCANOFF:
            begin
              rec_r[1] <= rec_r[0]; // [RL16]
              rec_r[0] <= 1'b0;
            end
            `CMCS_CMD_SCANON:
            begin
              rec_r[0] <= rec_r[0] | rec_r[1]; // [RL16]
              rec_r[1] <= 1'b0;
            end
            `CMCS_CMD_OCOMP:
              rec_r[2] <= arg_r[0];
            `CMCS_CMD_NULL:
            begin
              mem_we_r <= 1'b0;
              null_r <= 1'b1; // [RL17]
              first_r <= 32'h00000000;
              meas_src_on <= 1'b1;
              meas_req <= 1'b1;
              state_r <= S_MEAS;
            end
            `CMCS_CMD_PRESET, `CMCS_CMD_CRESET:
              mem_we_r <= 1'b0; // [RL3] [RL22]
            default:
              mem_we_r <= 1'b0;
          endcase
        end
        S_MEAS:
        begin
          if (meas_valid)
          begin
            if (ocomp_active && meas_src_on)
            begin
              first_r <= meas_data;
              meas_src_on <= 1'b0;
              meas_req <= 1'b1;
              state_r <= S_MEAS2;
            end
            else
            begin
              raw_r <= meas_data;
              state_r <= S_MEAS2;
            end
          end
        end
        S_MEAS2:
        begin
          if (!ocomp_active || meas_src_on)
          begin
            state_r <= null_r ? S_IDLE : S_SCALE;
            if (null_r)
            begin
              rec_r[74:43] <= raw_r; // [RL17]
              mem_we_r <= 1'b1;
              mem_wa_r <= chan_r;
              null_r <= 1'b0;
            end
            else
              scale_go_r <= 1'b1;
            meas_src_on <= 1'b1;
          end
          else if (meas_valid)
          begin
            raw_r <= first_r - meas_data; // [RL1]
            meas_src_on <= 1'b1;
          end
        end
        S_SCALE:
        begin
          if (scale_done)
          begin
            result_r <= rec_r[0] ? scaled : raw_r; // [RL12]
            state_r <= S_IDLE;
          end
        end
        S_WIPE:
        begin
          mem_we_r <= 1'b1;
          mem_wa_r <= wipe_r;
          wipe_r <= wipe_r + {{(CHW-1){1'b0}}, 1'b1};
          if (&wipe_r)
            state_r <= S_IDLE;
        end
        default:
          state_r <= S_IDLE;
      endcase
    end
  end
endmodule

// ### dv/cmcs_chk.sv
// port-level assertion checker for the channel config block
`timescale 1ns/1ps
module cmcs_chk #(
  parameter CHW = 7
) (
  input wire clock,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire meas_req,
  input wire meas_src_on,
  input wire meas_valid,
  input wire [31:0] meas_data,
  input wire monitor_active
);
  wire null_wr;
  assign null_wr = psel && penable && pwrite && paddr == 12'h000 && pwdata[3:0] == 4'h9;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  a_ready_access: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  a_no_slverr: assert property (psel && penable |-> !pslverr)
    else $error("error response on the bus");
  a_req_pulse: assert property (meas_req |=> !meas_req)
    else $error("reading request longer than one cycle");
  a_reset_quiet: assert property ($rose(rst_n) |-> !meas_req && !meas_src_on)
    else $error("meter outputs active out of reset");
  a_src_hold: assert property (meas_req |=> $stable(meas_src_on))
    else $error("source level moved under a pending reading");
  a_null_req: assert property (null_wr |-> ##[1:8] meas_req)
    else $error("null command issued no reading");
  a_write_ok: assert property (psel && penable && pwrite |-> pready && !pslverr)
    else $error("write not completed cleanly");
endmodule

bind cmcs_top cmcs_chk #(.CHW(CHW)) cmcs_chk_i (
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .meas_req(meas_req), .meas_src_on(meas_src_on), .meas_valid(meas_valid),
  .meas_data(meas_data), .monitor_active(monitor_active)
);

// ### dv/cmcs_tb.sv
// self-checking bench for the channel config block
`timescale 1ns/1ps
`include "cmcs_regs.vh"
module testbench;
  reg clock = 1'b0;
  reg rst_n = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h00000000;
  reg meas_valid = 1'b0;
  reg [31:0] meas_data = 32'h00000000;
  reg monitor_active = 1'b0;
  reg inject = 1'b0;
  reg [31:0] inj_data = 32'h00000000;
  reg [31:0] resp_on = 32'h00000000;
  reg [31:0] resp_off = 32'h00000000;
  reg [31:0] rd_q = 32'h00000000;
  reg [31:0] rd;
  reg [31:0] hz_t [0:4] = '{32'd3, 32'd19, 32'd20, 32'd199, 32'd200};
  reg [1:0] sp_t [0:4] = '{`CMCS_SPD_SLOW, `CMCS_SPD_SLOW, `CMCS_SPD_MED, `CMCS_SPD_MED,
    `CMCS_SPD_FAST};
  reg [31:0] dly_s [0:2] = '{`CMCS_DLY_SLOW_MS, `CMCS_DLY_MED_MS, `CMCS_DLY_FAST_MS};
  reg [31:0] min_s [0:2] = '{`CMCS_MIN_SLOW_MS, `CMCS_MIN_MED_MS, `CMCS_MIN_FAST_MS};
  reg [31:0] tmo_s [0:2] = '{`CMCS_TMO_SLOW_MS, `CMCS_TMO_MED_MS, `CMCS_TMO_FAST_MS};
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire meas_req;
  wire meas_src_on;
  integer mismatches = 0;
  integer check_count = 0;
  integer i;

  cmcs_top cmcs_top_i (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas_req(meas_req), .meas_src_on(meas_src_on), .meas_valid(meas_valid),
    .meas_data(meas_data), .monitor_active(monitor_active)
  );

  always #5 clock = ~clock;

  always @(posedge clock)
    if (psel && penable && pready)
      rd_q <= prdata;

  // meter stand-in: answers a cycle after each request, data line churns when idle
  always @(posedge clock)
  begin
    meas_valid <= meas_req || inject;
    if (meas_req || inject)
      meas_data <= inject ? inj_data : (meas_src_on ? resp_on : resp_off);
    else
      meas_data <= ~meas_data;
  end

  task complete_run;
  begin
    if (mismatches == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask

  task chk(input [8*8-1:0] name, input [31:0] e, input [31:0] got);
  begin
    check_count = check_count + 1;
    if (got !== e)
    begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED %0s expected %h seen %h", name, e, got);
    end
  end
  endtask

  // read data is captured at the sampling edge, picked up half a cycle later
  task apb(input wr, input [11:0] a, input [31:0] d);
  begin
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clock);
    rd = rd_q;
  end
  endtask

  task rchk(input [8*8-1:0] name, input [11:0] a, input [31:0] e);
  begin
    apb(1'b0, a, 32'h00000000);
    chk(name, e, rd);
  end
  endtask

  task echk;
  begin
    apb(1'b0, `CMCS_OFF_STATUS, 32'h00000000);
    chk("err", 32'h00000001, {31'h0, rd[`CMCS_ST_ERR]});
  end
  endtask

  task cmd(input [3:0] code, input [6:0] ch, input [15:0] arg);
  begin
    apb(1'b1, `CMCS_OFF_CMD, {arg, 1'b0, ch, 4'h0, code});
    rd = 32'h00000001;
    while (rd[`CMCS_ST_BUSY] !== 1'b0)
      apb(1'b0, `CMCS_OFF_STATUS, 32'h00000000);
  end
  endtask

  task mon(input [31:0] raw, input [31:0] e);
  begin
    @(posedge clock);
    monitor_active <= 1'b1;
    inject <= 1'b1;
    inj_data <= raw;
    @(posedge clock);
    inject <= 1'b0;
    repeat (4) @(posedge clock);
    rchk("result", `CMCS_OFF_RESULT, e);
    @(posedge clock);
    monitor_active <= 1'b0;
  end
  endtask

  task t_resets;
  begin
    cmd(`CMCS_CMD_SELECT, 7'd1, 16'h0000);
    rchk("gain", `CMCS_OFF_GAIN, `CMCS_GAIN_ONE);
    apb(1'b1, `CMCS_OFF_GAIN, 32'h00020000);
    apb(1'b1, `CMCS_OFF_OFST, 32'h00000005);
    cmd(`CMCS_CMD_PRESET, 7'd1, 16'h0000);
    cmd(`CMCS_CMD_CRESET, 7'd1, 16'h0000);
    rchk("gain", `CMCS_OFF_GAIN, 32'h00020000);
    cmd(`CMCS_CMD_CONF, 7'd1, {13'h0, `CMCS_FN_DCV});
    rchk("gain", `CMCS_OFF_GAIN, `CMCS_GAIN_ONE);
    rchk("ofst", `CMCS_OFF_OFST, 32'h00000000);
    apb(1'b1, `CMCS_OFF_GAIN, 32'h00020000);
    cmd(`CMCS_CMD_CFGCHG, 7'd1, 16'h0000);
    rchk("gain", `CMCS_OFF_GAIN, `CMCS_GAIN_ONE);
    apb(1'b1, `CMCS_OFF_OFST, 32'h00000009);
    cmd(`CMCS_CMD_DMMOFF, 7'd1, 16'h0000);
    rchk("ofst", `CMCS_OFF_OFST, 32'h00000000);
    apb(1'b1, `CMCS_OFF_OFST, 32'h00000009);
    cmd(`CMCS_CMD_FRESET, 7'd0, 16'h0000);
    cmd(`CMCS_CMD_SELECT, 7'd1, 16'h0000);
    rchk("ofst", `CMCS_OFF_OFST, 32'h00000000);
  end
  endtask

  task t_filter;
  begin
    cmd(`CMCS_CMD_SELECT, 7'd2, 16'h0000);
    cmd(`CMCS_CMD_FUNC, 7'd2, {13'h0, `CMCS_FN_ACV});
    for (i = 0; i < 5; i = i + 1)
    begin
      apb(1'b1, `CMCS_OFF_FREQ, hz_t[i]);
      rchk("delay", `CMCS_OFF_DELAY, dly_s[sp_t[i]]);
      rchk("mindly", `CMCS_OFF_DLYSET, min_s[sp_t[i]]);
    end
    cmd(`CMCS_CMD_PRESET, 7'd2, 16'h0000);
    rchk("delay", `CMCS_OFF_DELAY, `CMCS_DLY_FAST_MS);
    cmd(`CMCS_CMD_CONF, 7'd2, {13'h0, `CMCS_FN_ACV});
    rchk("delay", `CMCS_OFF_DELAY, `CMCS_DLY_MED_MS);
    apb(1'b1, `CMCS_OFF_FREQ, 32'd3);
    cmd(`CMCS_CMD_FUNC, 7'd2, {13'h0, `CMCS_FN_DCV});
    cmd(`CMCS_CMD_FUNC, 7'd2, {13'h0, `CMCS_FN_ACV});
    rchk("delay", `CMCS_OFF_DELAY, `CMCS_DLY_MED_MS);
    cmd(`CMCS_CMD_FUNC, 7'd2, {13'h0, `CMCS_FN_FREQ});
    for (i = 0; i < 5; i = i + 1)
    begin
      apb(1'b1, `CMCS_OFF_FREQ, hz_t[i]);
      rchk("tmo", `CMCS_OFF_TMO, tmo_s[sp_t[i]]);
    end
    cmd(`CMCS_CMD_CRESET, 7'd2, 16'h0000);
    rchk("tmo", `CMCS_OFF_TMO, `CMCS_TMO_FAST_MS);
    cmd(`CMCS_CMD_CONF, 7'd2, {13'h0, `CMCS_FN_FREQ});
    rchk("tmo", `CMCS_OFF_TMO, `CMCS_TMO_MED_MS);
  end
  endtask

  task t_refuse;
  begin
    cmd(`CMCS_CMD_SELECT, 7'd5, 16'h0000);
    cmd(`CMCS_CMD_FUNC, 7'd5, {13'h0, `CMCS_FN_DCI});
    echk;
    cmd(`CMCS_CMD_SELECT, 7'd6, 16'h0000);
    apb(1'b1, `CMCS_OFF_CFG, 32'h00000800);
    cmd(`CMCS_CMD_SCALEON, 7'd6, 16'h0000);
    echk;
  end
  endtask

  task t_scale;
  begin
    cmd(`CMCS_CMD_SELECT, 7'd1, 16'h0000);
    apb(1'b1, `CMCS_OFF_GAIN, 32'h00020000);
    apb(1'b1, `CMCS_OFF_OFST, 32'h00000005);
    apb(1'b1, `CMCS_OFF_GAIN, 32'h7FFF0001);
    echk;
    rchk("gain", `CMCS_OFF_GAIN, 32'h00020000);
    apb(1'b1, `CMCS_OFF_CFG, 32'h00000400);
    apb(1'b0, `CMCS_OFF_CFG, 32'h00000000);
    chk("alarm", 32'h00000001, {31'h0, rd[10]});
    cmd(`CMCS_CMD_SCALEON, 7'd1, 16'h0000);
    apb(1'b0, `CMCS_OFF_CFG, 32'h00000000);
    chk("alarm", 32'h00000000, {31'h0, rd[10]});
    mon(32'd100, 32'd195);
    cmd(`CMCS_CMD_SCANOFF, 7'd1, 16'h0000);
    rchk("gain", `CMCS_OFF_GAIN, 32'h00020000);
    mon(32'd100, 32'd100);
    cmd(`CMCS_CMD_SCANON, 7'd1, 16'h0000);
    mon(32'd100, 32'd195);
  end
  endtask

  task t_comp;
  begin
    resp_on = 32'd500;
    resp_off = 32'd100;
    cmd(`CMCS_CMD_SELECT, 7'd3, 16'h0000);
    cmd(`CMCS_CMD_FUNC, 7'd3, {13'h0, `CMCS_FN_OHM2});
    apb(1'b1, `CMCS_OFF_CFG, 32'h00000000);
    cmd(`CMCS_CMD_OCOMP, 7'd3, 16'h0001);
    cmd(`CMCS_CMD_NULL, 7'd3, 16'h0000);
    rchk("ofst", `CMCS_OFF_OFST, 32'd400);
    apb(1'b1, `CMCS_OFF_CFG, 32'h00030000);
    cmd(`CMCS_CMD_NULL, 7'd3, 16'h0000);
    rchk("ofst", `CMCS_OFF_OFST, 32'd500);
    cmd(`CMCS_CMD_FUNC, 7'd3, {13'h0, `CMCS_FN_OHM4});
    cmd(`CMCS_CMD_OCOMP, 7'd3, 16'h0001);
    cmd(`CMCS_CMD_FUNC, 7'd3, {13'h0, `CMCS_FN_OHM2});
    apb(1'b1, `CMCS_OFF_CFG, 32'h00000000);
    cmd(`CMCS_CMD_NULL, 7'd3, 16'h0000);
    rchk("ofst", `CMCS_OFF_OFST, 32'd500);
  end
  endtask

  task t_label;
  begin
    apb(1'b1, `CMCS_OFF_LABEL, 32'h00505349);
    rchk("label", `CMCS_OFF_LABEL, 32'h00505349);
    apb(1'b1, `CMCS_OFF_LABEL, 32'h00314142);
    echk;
    rchk("label", `CMCS_OFF_LABEL, 32'h00505349);
    apb(1'b1, `CMCS_OFF_LABEL, 32'h00412342);
    rchk("label", `CMCS_OFF_LABEL, 32'h00505349);
    apb(1'b1, `CMCS_OFF_LABEL, 32'h0023435F);
    rchk("label", `CMCS_OFF_LABEL, 32'h0023435F);
  end
  endtask

  initial
  begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    // channel store survives reset, so wipe it before anything else
    cmd(`CMCS_CMD_FRESET, 7'd0, 16'h0000);
    t_resets;
    t_filter;
    t_refuse;
    t_scale;
    t_comp;
    t_label;
    complete_run;
  end

  initial
  begin
    #200000;
    mismatches = mismatches + 1;
    complete_run;
  end
endmodule
